// ===== src/adc_conversion_sequencer.sv
// conversion sequencer: prescaler, start and completion timing, selection buffering
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps

module adc_conversion_sequencer import adc_seq_pkg::*; (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic trigger_i,
  input wire logic [9:0] result_i,
  output logic converter_enable_o,
  output logic high_speed_o,
  output logic converter_clock_o,
  output logic sample_hold_o,
  output logic converting_o,
  output logic [4:0] channel_select_bits_o,
  output logic [1:0] reference_select_bits_o
);

  // ************************************************************
  // helpers
  // ************************************************************

  // divider ratio; high speed halves it but never below two
  function automatic logic [8:0] divider_ratio(input logic [2:0] sel, input logic fast);
    logic [8:0] ratio;
    ratio = 9'h002 << sel;
    if (fast && sel != 3'h0) begin
      ratio = ratio >> 1;
    end
    return ratio;
  endfunction : divider_ratio

  function automatic logic is_differential(input logic [4:0] chan);
    return chan >= FIRST_DIFF_CHANNEL;
  endfunction : is_differential

  // ************************************************************
  // declarations
  // ************************************************************
  logic [1:0] rst_sync;
  logic rst_n;
  ctrl_type ctrl;
  select_type temp_sel;
  select_type work_sel;
  logic [9:0] data_reg;
  state_type state;
  logic [7:0] pre_cnt;
  logic half_clk;
  logic [5:0] hcnt;
  logic [5:0] len_h;
  logic [5:0] samp_h;
  logic first_pending;
  logic [2:0] trig_sync;
  logic trig_level;

  // ************************************************************
  // reset release
  // ************************************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ************************************************************
  // bus decode
  // ************************************************************
  wire bus_req = avs_read_i | avs_write_i;
  wire bus_write = avs_write_i & ~avs_waitrequest_o;
  wire wr_ctrl = bus_write & (avs_address_i == CTRL_OFFSET);
  wire wr_select = bus_write & (avs_address_i == SELECT_OFFSET);
  wire ctrl_type wd_ctrl = ctrl_type'(avs_writedata_i[8:0]);

  // one wait state on every access; readdata is loaded while it stands
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
    end
  end

  wire [31:0] status_word = {21'h0, half_clk, first_pending, state == CONVERTING,
                             work_sel.reference_select_bits, 1'b0, work_sel.channel_select_bits};
  wire [31:0] read_mux =
      (avs_address_i == CTRL_OFFSET) ? {23'h0, ctrl} :
      (avs_address_i == SELECT_OFFSET) ? {24'h0, temp_sel.reference_select_bits, 1'b0,
                                          temp_sel.channel_select_bits} :
      (avs_address_i == STATUS_OFFSET) ? status_word :
      (avs_address_i == DATA_OFFSET) ? {22'h0, data_reg} : 32'h0000_0000;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= read_mux;
    end
  end

  // ************************************************************
  // prescaler and converter clock edges
  // ************************************************************
  wire [8:0] ratio = divider_ratio(ctrl.prescale_select_field, ctrl.high_speed_mode_bit);
  wire [7:0] rise_at = 8'(ratio - 9'h001);
  wire [7:0] fall_at = 8'((ratio >> 1) - 9'h001);
  wire rise_tick = ctrl.converter_enable_bit & (pre_cnt == rise_at);
  wire fall_tick = ctrl.converter_enable_bit & (pre_cnt == fall_at);
  wire half_tick = rise_tick | fall_tick;
  // a smaller ratio written mid-count would otherwise let the 8-bit counter wrap
  wire pre_over = pre_cnt > rise_at;

  // ************************************************************
  // trigger synchroniser: a change counts when stages two and three agree
  // ************************************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      trig_sync <= 3'h0;
      trig_level <= 1'b0;
    end else begin
      trig_sync <= {trig_sync[1:0], trigger_i};
      if (trig_sync[1] == trig_sync[2]) begin
        trig_level <= trig_sync[2];
      end
    end
  end

  wire trig_rise = (trig_sync[1] == trig_sync[2]) & trig_sync[2] & ~trig_level;
  wire free_run = ctrl.auto_trigger_enable_bit & ctrl.trigger_on_complete;
  // edges while converting are dropped, never queued
  wire trig_start = trig_rise & ctrl.converter_enable_bit & ctrl.auto_trigger_enable_bit
                    & ~ctrl.trigger_on_complete & (state != CONVERTING);

  // ************************************************************
  // conversion timing
  // ************************************************************
  wire [5:0] hcnt_inc = hcnt + 6'h01;
  wire done = (state == CONVERTING) & half_tick & (hcnt_inc == len_h);
  wire sample_now = (state == CONVERTING) & half_tick & (hcnt_inc == samp_h);
  wire user_start = (state == ARMED) & rise_tick;
  wire conv_start = user_start | trig_start;
  wire restart = done & free_run;
  wire diff_sel = is_differential(work_sel.channel_select_bits);
  // differential starts with the half-rate clock high lose one cycle to alignment
  wire diff_long = diff_sel & (half_clk | restart);

  wire [5:0] next_len_h = first_pending ? FIRST_LEN_HALVES :
                          trig_start ? AUTO_LEN_HALVES :
                          diff_long ? DIFF_LONG_LEN_HALVES : NORMAL_LEN_HALVES;
  wire [5:0] next_samp_h = first_pending ? FIRST_SAMPLE_HALVES :
                           trig_start ? AUTO_SAMPLE_HALVES :
                           diff_long ? DIFF_LONG_SAMPLE_HALVES : NORMAL_SAMPLE_HALVES;

  // working selection stays frozen until the last converter cycle
  wire sel_locked = (state == CONVERTING) & (hcnt < (len_h - UNLOCK_HALVES));

  // ************************************************************
  // start bit and complete flag
  // ************************************************************
  wire set_start = (wr_ctrl & wd_ctrl.start_conversion_bit) | trig_start;
  wire clear_flag = wr_ctrl & wd_ctrl.conversion_complete_flag;
  wire next_enable = wr_ctrl ? wd_ctrl.converter_enable_bit : ctrl.converter_enable_bit;
  // a fresh write of start wins over the completion clear
  wire next_start = next_enable & (set_start | (ctrl.start_conversion_bit & ~(done & ~free_run)));

  // ************************************************************
  // control register
  // ************************************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= ctrl_type'(CTRL_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl.converter_enable_bit <= wd_ctrl.converter_enable_bit;
        ctrl.auto_trigger_enable_bit <= wd_ctrl.auto_trigger_enable_bit;
        ctrl.trigger_on_complete <= wd_ctrl.trigger_on_complete;
        ctrl.prescale_select_field <= wd_ctrl.prescale_select_field;
        ctrl.high_speed_mode_bit <= wd_ctrl.high_speed_mode_bit;
      end
      ctrl.start_conversion_bit <= next_start;
      // the set wins over a clear in the same cycle
      ctrl.conversion_complete_flag <= done | (ctrl.conversion_complete_flag & ~clear_flag);
    end
  end

  // ************************************************************
  // prescaler counter and clocks
  // ************************************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 8'h00;
    end else if (!ctrl.converter_enable_bit || trig_start || rise_tick || pre_over) begin
      pre_cnt <= 8'h00;
    end else begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  // half-rate clock restarts with the prescaler
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      converter_clock_o <= 1'b0;
      half_clk <= 1'b0;
    end else if (!ctrl.converter_enable_bit || trig_start) begin
      converter_clock_o <= 1'b0;
      half_clk <= 1'b0;
    end else begin
      if (rise_tick) begin
        converter_clock_o <= 1'b1;
        half_clk <= ~half_clk;
      end else if (fall_tick) begin
        converter_clock_o <= 1'b0;
      end
    end
  end

  // ************************************************************
  // sequencer state
  // ************************************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= IDLE;
    end else if (!ctrl.converter_enable_bit) begin
      state <= IDLE;
    end else begin
      unique case (state)
        IDLE: begin
          if (trig_start) begin
            state <= CONVERTING;
          end else if (ctrl.start_conversion_bit) begin
            state <= ARMED;
          end
        end
        ARMED: begin
          if (conv_start) begin
            state <= CONVERTING;
          end
        end
        CONVERTING: begin
          if (done && !restart) begin
            state <= next_start ? ARMED : IDLE;
          end
        end
      endcase
    end
  end

  // half-cycle counter and the length chosen at each start
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hcnt <= 6'h00;
      len_h <= NORMAL_LEN_HALVES;
      samp_h <= NORMAL_SAMPLE_HALVES;
    end else if (conv_start || restart) begin
      hcnt <= 6'h00;
      len_h <= next_len_h;
      samp_h <= next_samp_h;
    end else if (state == CONVERTING && half_tick) begin
      hcnt <= hcnt_inc;
    end
  end

  // extended conversion is owed after every enable
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      first_pending <= 1'b1;
    end else if (!ctrl.converter_enable_bit) begin
      first_pending <= 1'b1;
    end else if (conv_start) begin
      first_pending <= 1'b0;
    end
  end

  // ************************************************************
  // selection buffering and result
  // ************************************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      temp_sel <= select_type'(SELECT_RESET);
      work_sel <= select_type'(SELECT_RESET);
    end else begin
      if (wr_select) begin
        temp_sel.channel_select_bits <= avs_writedata_i[4:0];
        temp_sel.reference_select_bits <= avs_writedata_i[SELECT_REF_POS +: 2];
      end
      // start edge locks the copy taken in the cycle before it
      if (!sel_locked && !conv_start && !restart) begin
        work_sel <= temp_sel;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= DATA_RESET;
    end else if (done) begin
      data_reg <= result_i;
    end
  end

  // ************************************************************
  // outputs to the analog core
  // ************************************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sample_hold_o <= 1'b0;
      converting_o <= 1'b0;
      converter_enable_o <= 1'b0;
      high_speed_o <= 1'b0;
      channel_select_bits_o <= 5'h00;
      reference_select_bits_o <= 2'h0;
    end else begin
      sample_hold_o <= sample_now;
      // rises on the start edge and falls on a completion without free-running restart, in step with sample_hold_o
      converting_o <= conv_start | (ctrl.converter_enable_bit & (state == CONVERTING) & ~(done & ~restart));
      converter_enable_o <= ctrl.converter_enable_bit;
      high_speed_o <= ctrl.high_speed_mode_bit;
      channel_select_bits_o <= work_sel.channel_select_bits;
      reference_select_bits_o <= work_sel.reference_select_bits;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  a_prescale_held: assert property (!ctrl.converter_enable_bit |=> pre_cnt == 8'h00)
    else $error("prescaler ran while disabled");
  a_start_on_edge: assert property (state == ARMED && !rise_tick && !trig_start |=> state != CONVERTING)
    else $error("conversion began off a converter clock edge");
  a_normal_length: assert property (user_start && !first_pending && !diff_sel |=> len_h == 6'h1A)
    else $error("ordinary conversion not 13 cycles");
  a_first_extended: assert property (conv_start && first_pending |=> len_h == 6'h32 && samp_h == 6'h1B)
    else $error("first conversion not extended");
  a_result_flag: assert property (done |=> ctrl.conversion_complete_flag && data_reg == $past(result_i))
    else $error("result and flag not stored together");
  a_single_clear: assert property (done && !free_run && !set_start |=> !ctrl.start_conversion_bit)
    else $error("start bit not cleared in single mode");
  a_trigger_reset: assert property (trig_start |=> pre_cnt == 8'h00 ##1 state == CONVERTING)
    else $error("trigger did not reset prescaler");
  a_trigger_sync: assert property (trig_start |-> $past(trigger_i, 3) && $past(trigger_i, 2))
    else $error("trigger taken without three stage sync");
  a_free_running: assert property (done && free_run |=> ctrl.start_conversion_bit && state == CONVERTING)
    else $error("free running did not restart");
  a_diff_restart: assert property (restart && diff_sel && !first_pending |=> len_h == 6'h1C)
    else $error("differential restart not 14 cycles");
  a_sel_frozen: assert property (sel_locked && !done |=> $stable(work_sel))
    else $error("selection changed during conversion");
  a_trigger_ignored: assert property (trig_rise && state == CONVERTING && !done |=>
                                      (hcnt == $past(hcnt) || hcnt == $past(hcnt_inc)) && len_h == $past(len_h))
    else $error("trigger restarted a running conversion");

  c_single: cover property (user_start ##[1:1000] done);
  c_triggered: cover property (trig_start ##[1:1000] sample_now);
  c_free_run: cover property (restart ##[1:1000] restart);
  c_diff_long: cover property (user_start && diff_long && !first_pending);

endmodule : adc_conversion_sequencer

// ===== common/adc_seq_pkg.sv
// constants, register layout and types for the conversion sequencer
package adc_seq_pkg;

  // ************************************************************
  // register offsets (byte addresses, one word each)
  // ************************************************************
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] SELECT_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;
  localparam logic [3:0] DATA_OFFSET = 4'hC;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam logic [6:0] SELECT_RESET = 7'h00;
  localparam logic [9:0] DATA_RESET = 10'h000;

  // ************************************************************
  // field positions in the status word
  // ************************************************************
  localparam int unsigned STATUS_BUSY_POS = 8;
  localparam int unsigned STATUS_FIRST_POS = 9;
  localparam int unsigned STATUS_HALF_POS = 10;
  localparam int unsigned SELECT_REF_POS = 6;

  // channel codes at or above this value select a differential pair
  localparam logic [4:0] FIRST_DIFF_CHANNEL = 5'h08;

  // ************************************************************
  // timing in converter clock cycles, counted in half cycles
  // ************************************************************
  localparam int unsigned NORMAL_CYCLES = 13;
  localparam int unsigned FIRST_CYCLES = 25;
  localparam int unsigned DIFF_LONG_CYCLES = 14;
  localparam logic [5:0] NORMAL_LEN_HALVES = 6'(2 * NORMAL_CYCLES);
  localparam logic [5:0] FIRST_LEN_HALVES = 6'(2 * FIRST_CYCLES);
  localparam logic [5:0] DIFF_LONG_LEN_HALVES = 6'(2 * DIFF_LONG_CYCLES);
  localparam logic [5:0] AUTO_LEN_HALVES = 6'h1B;    // 13.5 cycles
  localparam logic [5:0] NORMAL_SAMPLE_HALVES = 6'h03; // 1.5 cycles
  localparam logic [5:0] FIRST_SAMPLE_HALVES = 6'h1B;  // 13.5 cycles
  localparam logic [5:0] DIFF_LONG_SAMPLE_HALVES = 6'h05; // 2.5 cycles
  localparam logic [5:0] AUTO_SAMPLE_HALVES = 6'h04;   // 2 cycles
  localparam logic [5:0] UNLOCK_HALVES = 6'h02;        // last cycle

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic high_speed_mode_bit;
    logic [2:0] prescale_select_field;
    logic trigger_on_complete;
    logic conversion_complete_flag;
    logic auto_trigger_enable_bit;
    logic start_conversion_bit;
    logic converter_enable_bit;
  } ctrl_type;

  typedef struct packed {
    logic [1:0] reference_select_bits;
    logic [4:0] channel_select_bits;
  } select_type;

  typedef enum logic [1:0] {IDLE, ARMED, CONVERTING} state_type;

endpackage : adc_seq_pkg

// ===== tb/analog_core_model.sv
// behavioural model of the analog converter core behind the sequencer
`timescale 1ns/1ps

module analog_core_model (
  input wire logic clk_i,
  input wire logic sample_hold_i,
  input wire logic [4:0] channel_select_bits_i,
  input wire logic [1:0] reference_select_bits_i,
  output logic [9:0] result_o
);
  // ************************************************************
  // sample-and-hold capture
  // ************************************************************
  // result tags the channel held at sampling, so a late mux change shows up
  initial result_o = 10'h2AA;
  always @(posedge clk_i) begin
    if (sample_hold_i === 1'b1) begin
      result_o <= {3'h5, reference_select_bits_i, channel_select_bits_i};
    end
  end
endmodule : analog_core_model

// ===== tb/adc_conversion_sequencer_bench.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps

module adc_conversion_sequencer_bench import adc_seq_pkg::*;;
  logic clk_i, resetn_i, avs_read_i, avs_write_i, trigger_i;
  logic [3:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic avs_waitrequest_o, converter_enable_o, high_speed_o, converter_clock_o, sample_hold_o, converting_o;
  logic [9:0] result_i;
  logic [4:0] channel_select_bits_o;
  logic [1:0] reference_select_bits_o;
  int n_errors, num_checks, c, s;

  adc_conversion_sequencer dut (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .trigger_i(trigger_i),
    .result_i(result_i), .converter_enable_o(converter_enable_o), .high_speed_o(high_speed_o),
    .converter_clock_o(converter_clock_o), .sample_hold_o(sample_hold_o), .converting_o(converting_o),
    .channel_select_bits_o(channel_select_bits_o), .reference_select_bits_o(reference_select_bits_o));
  analog_core_model core (.clk_i(clk_i), .sample_hold_i(sample_hold_o),
    .channel_select_bits_i(channel_select_bits_o), .reference_select_bits_i(reference_select_bits_o),
    .result_o(result_i));

  // ************************************************************
  // clock, reporting and bus tasks
  // ************************************************************
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task stop_test;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask : check

  // request held until the edge where waitrequest is seen low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  // length of a conversion and sample position, in system clocks
  task measure(input int len, input int samp);
    c = 0;
    s = -1;
    while (converting_o !== 1'b1) @(posedge clk_i);
    while (converting_o === 1'b1) begin
      if (sample_hold_o === 1'b1) s = c;
      c++;
      @(posedge clk_i);
    end
    check(c, len);
    check(s, samp);
  endtask : measure

  task wait_pulse;
    @(posedge clk_i);
    while (sample_hold_o !== 1'b1) @(posedge clk_i);
  endtask : wait_pulse

  // ************************************************************
  // watchdog: whole run is a few thousand cycles
  // ************************************************************
  initial begin
    repeat (40000) @(posedge clk_i);
    n_errors++;
    stop_test();
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    resetn_i = 1'b0;
    {avs_read_i, avs_write_i, trigger_i} = 3'h0;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h0000_0000;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // reset values, unmapped place ignored and read as zero
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    // only the status word is nonzero: the extended conversion is owed
    for (int a = 0; a < 16; a += 2) begin
      bus(1'b0, 4'(a), 32'h0);
      check(rd, (4'(a) == STATUS_OFFSET) ? (32'h0000_0001 << STATUS_FIRST_POS) : 32'h0000_0000);
    end
    check(converter_clock_o, 1'b0);
    bus(1'b1, SELECT_OFFSET, 32'h0000_0043);
    repeat (4) @(posedge clk_i);
    check({reference_select_bits_o, channel_select_bits_o}, 7'h23);
    // first conversion after enable is the extended one
    bus(1'b1, CTRL_OFFSET, 32'h0000_0003);
    measure(50, 27);
    bus(1'b0, DATA_OFFSET, 32'h0);
    check(rd, {22'h0, 3'h5, 2'h1, 5'h03});
    bus(1'b0, CTRL_OFFSET, 32'h0);
    check(rd, 32'h0000_0009);
    // ordinary conversions, prescale and high-speed ratios
    bus(1'b1, CTRL_OFFSET, 32'h0000_000B);
    measure(26, 3);
    bus(1'b1, CTRL_OFFSET, 32'h0000_006B);
    measure(208, 24);
    bus(1'b1, CTRL_OFFSET, 32'h0000_016B);
    measure(104, 12);
    check({converter_enable_o, high_speed_o}, 2'h3);
    // selection frozen while converting, picked up at the end
    bus(1'b1, CTRL_OFFSET, 32'h0000_000B);
    repeat (4) @(posedge clk_i);
    bus(1'b1, SELECT_OFFSET, 32'h0000_0005);
    repeat (3) @(posedge clk_i);
    check({converting_o, channel_select_bits_o}, 6'h23);
    while (converting_o === 1'b1) @(posedge clk_i);
    check({reference_select_bits_o, channel_select_bits_o}, 7'h05);
    // trigger edge: 3 sync stages, the prescaler reset edge, 2 converter cycles, output register
    bus(1'b1, CTRL_OFFSET, 32'h0000_000D);
    repeat (5) @(posedge clk_i);
    trigger_i <= 1'b1;
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (sample_hold_o !== 1'b1 && c < 100);
    check(c, 9);
    trigger_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    trigger_i <= 1'b1; // edge in mid-conversion
    s = 0;
    repeat (80) begin
      @(posedge clk_i);
      if (sample_hold_o === 1'b1) s++;
    end
    check(s, 0);
    trigger_i <= 1'b0;
    bus(1'b1, CTRL_OFFSET, 32'h0000_0000);
    // the first edge may still show the last enabled clock level
    @(posedge clk_i);
    repeat (10) begin
      @(posedge clk_i);
      check({converter_enable_o, converter_clock_o}, 2'h0);
    end
    // free running, single ended then differential
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, SELECT_OFFSET, k ? 32'h0000_0008 : 32'h0000_0003);
      repeat (1250) @(posedge clk_i);
      bus(1'b1, CTRL_OFFSET, 32'h0000_0017);
      wait_pulse();
      wait_pulse();
      c = 0;
      do begin
        @(posedge clk_i);
        c++;
      end while (sample_hold_o !== 1'b1 && c < 100);
      check(c, k ? 28 : 26);
      bus(1'b0, CTRL_OFFSET, 32'h0);
      check(rd[1], 1'b1);
      bus(1'b1, CTRL_OFFSET, 32'h0000_0000);
    end
    stop_test();
  end
endmodule : adc_conversion_sequencer_bench
